/* File: common/occ_pkg.sv */
/*
  Constants for the overload commutation controller: register offsets,
  field positions, reset values and codes.
  Assumes a 7-bit register index on the plain register port.
*/
`default_nettype none
package occ_pkg;
  // Register offsets
  localparam logic [6:0] OCC_ADDR_GLOBAL_CONF   = 7'h00;
  localparam logic [6:0] OCC_ADDR_REF_CONF      = 7'h01;
  localparam logic [6:0] OCC_ADDR_SWITCH_VEL    = 7'h1d;
  localparam logic [6:0] OCC_ADDR_FORMAT        = 7'h40;
  localparam logic [6:0] OCC_ADDR_STATE         = 7'h41;
  localparam logic [6:0] OCC_ADDR_IRQ_STATUS    = 7'h42;
  localparam logic [6:0] OCC_ADDR_IRQ_MASK      = 7'h43;
  localparam logic [6:0] OCC_ADDR_THRESH_VEL    = 7'h60;
  localparam logic [6:0] OCC_ADDR_TIMING        = 7'h61;
  localparam logic [6:0] OCC_ADDR_LSP_TIMER     = 7'h62;
  localparam logic [6:0] OCC_ADDR_CHOP_LOW      = 7'h6c;
  localparam logic [6:0] OCC_ADDR_CHOP_HIGH     = 7'h6d;
  // Field positions
  localparam int OCC_MODE_LSB        = 21;
  localparam int OCC_AUTO_COVER_BIT  = 0;
  localparam int OCC_UPPER_LSB       = 0;
  localparam int OCC_STALL_LSB       = 8;
  localparam int OCC_BLANK_LSB       = 16;
  localparam int OCC_STALL_SCALE_SH  = 4;
  localparam int OCC_THRESH_WIDTH    = 24;
  // Codes
  localparam logic [1:0] OCC_MODE_ON      = 2'h1;
  localparam logic [3:0] OCC_FMT_F1_A     = 4'hb;
  localparam logic [3:0] OCC_FMT_F1_B     = 4'ha;
  localparam logic [3:0] OCC_FMT_F2_A     = 4'hd;
  localparam logic [3:0] OCC_FMT_F2_B     = 4'hc;
  // Interrupt bits
  localparam int OCC_IRQ_STALL    = 0;
  localparam int OCC_IRQ_OVERLOAD = 1;
  localparam int OCC_IRQ_FORCED   = 2;
  localparam int OCC_IRQ_WIDTH    = 3;
  // Reset values
  localparam logic [31:0] OCC_RESET_WORD = 32'h0000_0000;
  localparam logic [3:0]  OCC_RESET_FMT  = 4'h0;
endpackage : occ_pkg
`default_nettype wire

/* File: core/occ_ctrl.sv */
/*
  Overload commutation controller: measures approval pulses from the
  driver, gates and forces internal steps, drives the handshake enable
  and selects the chopper datagram.
  Assumes approval input is asynchronous; velocity, step request and
  driver stall bit come from logic on the same clock.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module occ_ctrl
  import occ_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [6:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Motion side
  input  wire logic [31:0] internal_velocity,
  input  wire logic        step_request,
  input  wire logic        driver_stall_status,
  output logic             step_out,
  output logic             full_step_mode,
  output logic             stall_report,
  // Driver pins
  input  wire logic        step_approval_input,
  output logic             commutation_enable_output,
  output logic             commutation_enable_oe_n,
  // Chopper datagram
  output logic      [31:0] chopper_datagram,
  output logic             cover_send,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] global_configuration;
  logic [31:0] reference_configuration;
  logic [31:0] interface_switch_velocity;
  logic [31:0] overload_threshold_velocity;
  logic [31:0] overload_timing_limits;
  logic [31:0] low_speed_step_timer;
  logic [31:0] chopper_datagram_low;
  logic [31:0] chopper_datagram_high;
  logic [3:0]  driver_output_format;
  logic [OCC_IRQ_WIDTH-1:0] irq_status;
  logic [OCC_IRQ_WIDTH-1:0] irq_mask;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction : hit

  always_ff @(posedge clock) begin
    if (rst) begin
      global_configuration        <= OCC_RESET_WORD;
      reference_configuration     <= OCC_RESET_WORD;
      interface_switch_velocity   <= OCC_RESET_WORD;
      overload_threshold_velocity <= OCC_RESET_WORD;
      overload_timing_limits      <= OCC_RESET_WORD;
      low_speed_step_timer        <= OCC_RESET_WORD;
      chopper_datagram_low        <= OCC_RESET_WORD;
      chopper_datagram_high       <= OCC_RESET_WORD;
      driver_output_format        <= OCC_RESET_FMT;
      irq_mask                    <= '0;
    end else if (reg_write) begin
      if (hit(reg_addr, OCC_ADDR_GLOBAL_CONF)) global_configuration <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_REF_CONF)) reference_configuration <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_SWITCH_VEL)) interface_switch_velocity <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_THRESH_VEL)) begin
        overload_threshold_velocity <= {8'h00, reg_wdata[OCC_THRESH_WIDTH-1:0]};
      end
      if (hit(reg_addr, OCC_ADDR_TIMING)) overload_timing_limits <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_LSP_TIMER)) low_speed_step_timer <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_CHOP_LOW)) chopper_datagram_low <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_CHOP_HIGH)) chopper_datagram_high <= reg_wdata;
      if (hit(reg_addr, OCC_ADDR_FORMAT)) driver_output_format <= reg_wdata[3:0];
      if (hit(reg_addr, OCC_ADDR_IRQ_MASK)) irq_mask <= reg_wdata[OCC_IRQ_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic [1:0]  commutation_mode;
  logic        family_one;
  logic        family_two;
  logic        mode_on;
  logic        f1_enabled;
  logic        f2_enabled;
  logic [31:0] abs_velocity;
  logic        f1_active;
  logic        f2_active;
  logic        dc_active;
  logic        auto_cover;
  logic [7:0]  upper_limit;
  logic [11:0] stall_limit;
  logic [15:0] blank_cycles;

  assign commutation_mode = global_configuration[OCC_MODE_LSB +: 2];
  assign family_one = (driver_output_format == OCC_FMT_F1_A)
                   || (driver_output_format == OCC_FMT_F1_B);
  assign family_two = (driver_output_format == OCC_FMT_F2_A)
                   || (driver_output_format == OCC_FMT_F2_B);
  assign mode_on    = (commutation_mode == OCC_MODE_ON);
  assign f1_enabled = mode_on && family_one;
  assign f2_enabled = mode_on && family_two;
  assign abs_velocity = internal_velocity[31] ? 32'(-internal_velocity) : internal_velocity;
  assign f1_active  = f1_enabled && (abs_velocity > overload_threshold_velocity);
  assign f2_active  = f2_enabled
                   && ($signed(internal_velocity) >= $signed(overload_threshold_velocity));
  assign dc_active  = f1_active || f2_active;
  assign auto_cover = reference_configuration[OCC_AUTO_COVER_BIT];
  assign upper_limit  = overload_timing_limits[OCC_UPPER_LSB +: 8];
  assign stall_limit  = {overload_timing_limits[OCC_STALL_LSB +: 8], 4'h0};
  assign blank_cycles = overload_timing_limits[OCC_BLANK_LSB +: 16];

  ////////////////////////////////////////////////////////////////////////////
  // Approval pulse measurement

  logic        appr_meta;
  logic        appr_sync;
  logic        appr_prev;
  logic [15:0] pulse_len;
  logic [15:0] blank_cnt;
  logic        pulse_valid;
  logic        check_first;
  logic        pulse_end;
  logic        release_step;

  always_ff @(posedge clock) begin
    if (rst) begin
      appr_meta <= 1'b0;
      appr_sync <= 1'b0;
      appr_prev <= 1'b0;
    end else begin
      appr_meta <= step_approval_input;
      appr_sync <= appr_meta;
      appr_prev <= appr_sync;
    end
  end

  assign release_step = step_out && f1_active;
  assign pulse_end    = appr_prev && !appr_sync && pulse_valid && (blank_cnt == 16'h0000);

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_len <= '0;
    end else if (!appr_sync) begin
      pulse_len <= '0;
    end else if (pulse_len != 16'hffff) begin
      pulse_len <= pulse_len + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      blank_cnt   <= '0;
      pulse_valid <= 1'b0;
      check_first <= 1'b0;
    end else if (release_step) begin
      blank_cnt   <= blank_cycles;
      pulse_valid <= 1'b0;
      check_first <= 1'b1;
    end else begin
      if (blank_cnt != 16'h0000) blank_cnt <= blank_cnt - 16'h0001;
      if (appr_sync && !appr_prev && blank_cnt == 16'h0000) pulse_valid <= 1'b1;
      if (pulse_end) check_first <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall detection

  logic stall_flag;
  logic stall_event;

  assign stall_event = pulse_end && check_first && (pulse_len < 16'(stall_limit));

  always_ff @(posedge clock) begin
    if (rst) begin
      stall_flag <= 1'b0;
    end else if (pulse_end && check_first) begin
      stall_flag <= stall_event;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stall_report <= 1'b0;
    end else begin
      stall_report <= f1_enabled ? stall_flag : driver_stall_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step gating and low-speed timer

  logic        pause;
  logic        overload_event;
  logic [31:0] lsp_cnt;
  logic        force_step;
  logic        next_step;

  assign overload_event = pulse_end && (pulse_len >= 16'(upper_limit));
  assign force_step = f1_active && pause && (low_speed_step_timer != 32'h0)
                   && (lsp_cnt + 32'h1 >= low_speed_step_timer);

  always_ff @(posedge clock) begin
    if (rst) begin
      pause <= 1'b0;
    end else if (!f1_active) begin
      pause <= 1'b0;
    end else if (release_step) begin
      pause <= 1'b1;
    end else if (pulse_end) begin
      pause <= overload_event;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lsp_cnt <= '0;
    end else if (!pause || force_step || release_step) begin
      lsp_cnt <= '0;
    end else begin
      lsp_cnt <= lsp_cnt + 32'h1;
    end
  end

  // Family two keeps microstepping; the driver commutates itself
  assign next_step = f1_active ? (force_step || (step_request && !pause))
                               : step_request;

  always_ff @(posedge clock) begin
    if (rst) begin
      step_out       <= 1'b0;
      full_step_mode <= 1'b0;
    end else begin
      step_out       <= next_step;
      full_step_mode <= dc_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake enable output

  always_ff @(posedge clock) begin
    if (rst) begin
      commutation_enable_output <= 1'b0;
      commutation_enable_oe_n   <= 1'b1;
    end else begin
      commutation_enable_output <= f2_active;
      commutation_enable_oe_n   <= !f2_enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chopper datagram selection

  logic sel_high;

  always_ff @(posedge clock) begin
    if (rst) begin
      chopper_datagram <= OCC_RESET_WORD;
      sel_high         <= 1'b0;
      cover_send       <= 1'b0;
    end else begin
      chopper_datagram <= dc_active ? chopper_datagram_high : chopper_datagram_low;
      sel_high         <= dc_active;
      cover_send       <= auto_cover && (sel_high != dc_active);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and read port

  logic [OCC_IRQ_WIDTH-1:0] irq_events;
  logic [OCC_IRQ_WIDTH-1:0] irq_clear;

  assign irq_events = {force_step, overload_event, stall_event};
  assign irq_clear  = (reg_write && hit(reg_addr, OCC_ADDR_IRQ_STATUS))
                    ? reg_wdata[OCC_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;           // Set wins over clear
      irq        <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        OCC_ADDR_GLOBAL_CONF: reg_rdata <= global_configuration;
        OCC_ADDR_REF_CONF:    reg_rdata <= reference_configuration;
        OCC_ADDR_SWITCH_VEL:  reg_rdata <= interface_switch_velocity;
        OCC_ADDR_FORMAT:      reg_rdata <= {28'h0, driver_output_format};
        OCC_ADDR_STATE:       reg_rdata <= {26'h0, commutation_enable_output, full_step_mode,
                                            pause, stall_flag, f2_active, f1_active};
        OCC_ADDR_IRQ_STATUS:  reg_rdata <= {29'h0, irq_status};
        OCC_ADDR_IRQ_MASK:    reg_rdata <= {29'h0, irq_mask};
        default:              reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_PAUSE_BLOCKS: assert property (@(posedge clock) disable iff (rst)
    (f1_active && pause && !force_step) |=> !step_out)
    else $error("Step issued while paused");

  AST_MODE_GATE: assert property (@(posedge clock) disable iff (rst)
    (commutation_mode != OCC_MODE_ON) |=> !full_step_mode && !commutation_enable_output)
    else $error("Commutation active with mode off");

  AST_APPROVE: assert property (@(posedge clock) disable iff (rst)
    (f1_active && pulse_end && pulse_len < 16'(upper_limit) && !release_step) |=> !pause)
    else $error("Short pulse did not approve");

  AST_STALL_SET: assert property (@(posedge clock) disable iff (rst)
    (pulse_end && check_first && pulse_len < 16'(stall_limit)) |=> stall_flag ##1 stall_report || !f1_enabled)
    else $error("Short first pulse did not flag stall");

  AST_BLANK_HOLD: assert property (@(posedge clock) disable iff (rst)
    (blank_cnt != 16'h0000 && !release_step) |=> $stable(stall_flag) && $stable(check_first))
    else $error("Comparison during blank period");

  AST_STALL_SOURCE: assert property (@(posedge clock) disable iff (rst)
    f1_enabled |=> stall_report == $past(stall_flag))
    else $error("Wrong stall source reported");

  AST_THRESHOLD: assert property (@(posedge clock) disable iff (rst)
    (f1_enabled && abs_velocity <= overload_threshold_velocity && !family_two) |=> !full_step_mode)
    else $error("Active at or below threshold");

  AST_FORCE: assert property (@(posedge clock) disable iff (rst)
    force_step |=> step_out ##1 (lsp_cnt == 32'h0 || !pause))
    else $error("Low-speed timer did not force step");

  AST_COVER_SEL: assert property (@(posedge clock) disable iff (rst)
    dc_active |=> chopper_datagram == $past(chopper_datagram_high))
    else $error("Wrong chopper datagram while active");

  AST_HANDSHAKE: assert property (@(posedge clock) disable iff (rst)
    (f2_enabled && $signed(internal_velocity) >= $signed(overload_threshold_velocity))
      |=> commutation_enable_output && !commutation_enable_oe_n)
    else $error("Enable output not raised");

  AST_MICROSTEP: assert property (@(posedge clock) disable iff (rst)
    f2_enabled |=> step_out == $past(step_request))
    else $error("Microsteps gated in handshake form");

  AST_FULL_STEP: assert property (@(posedge clock) disable iff (rst)
    $rose(dc_active) |=> full_step_mode)
    else $error("No full-step switch on activation");

endmodule : occ_ctrl
`default_nettype wire

/* File: testbench/occ_driver_model.sv */
/*
  Driver stand-in: returns one pulse on the approval pin per request,
  after a set delay and for a set number of cycles.
  Assumes the controller's clock; the pin is driven low between pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module occ_driver_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Requests from the bench
  input  wire logic       fire,
  input  wire logic [7:0] delay_cycles,
  input  wire logic [7:0] pulse_cycles,
  // Driver pin
  output logic            approval_out,
  output logic            busy
);
  logic [7:0] count;
  logic [7:0] high_len;

  // Wait, then hold the pin high for the pulse length
  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
      approval_out <= 1'b0;
      count <= 8'h00;
      high_len <= 8'h00;
    end else if (fire && !busy) begin
      busy <= 1'b1;
      count <= delay_cycles;
      high_len <= pulse_cycles;
    end else if (busy) begin
      if (count != 8'h00) begin
        count <= count - 8'h01;
      end else if (high_len != 8'h00) begin
        approval_out <= 1'b1;
        high_len <= high_len - 8'h01;
      end else begin
        approval_out <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : occ_driver_model
`default_nettype wire

/* File: testbench/overload_commutation_ctrl_bench.sv */
/*
  Self-checking bench for the overload commutation controller.
  Assumes the driver model for the approval pin and a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module overload_commutation_ctrl_bench;
  import occ_pkg::*;
  logic clock, rst, reg_write, reg_read, step_request, driver_stall_status, fire, busy, approval;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, internal_velocity, chopper_datagram, d;
  logic step_out, full_step_mode, stall_report, commutation_enable_output, commutation_enable_oe_n;
  logic cover_send, irq;
  logic [7:0] delay_cycles, pulse_cycles;
  int fails, cmp_count, cycles;

  occ_ctrl dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .internal_velocity(internal_velocity), .step_request(step_request),
    .driver_stall_status(driver_stall_status), .step_out(step_out), .full_step_mode(full_step_mode),
    .stall_report(stall_report), .step_approval_input(approval),
    .commutation_enable_output(commutation_enable_output),
    .commutation_enable_oe_n(commutation_enable_oe_n), .chopper_datagram(chopper_datagram),
    .cover_send(cover_send), .irq(irq));
  occ_driver_model drv (.clock(clock), .rst(rst), .fire(fire), .delay_cycles(delay_cycles),
    .pulse_cycles(pulse_cycles), .approval_out(approval), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  // Reset, then format, limits, timer, mode and velocity
  task automatic setup(input logic [3:0] fmt, input logic [1:0] mode, input logic [31:0] lsp,
                       input logic [31:0] vel);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wr(OCC_ADDR_FORMAT, 32'(fmt));
    wr(OCC_ADDR_THRESH_VEL, 32'h0000_0010);
    wr(OCC_ADDR_TIMING, 32'h0010_0114);
    wr(OCC_ADDR_LSP_TIMER, lsp);
    wr(OCC_ADDR_GLOBAL_CONF, 32'(mode) << OCC_MODE_LSB);
    internal_velocity <= vel;
    wait_cyc(4);
  endtask : setup

  task automatic step(input logic exp);
    @(posedge clock);
    step_request <= 1'b1;
    @(posedge clock);
    step_request <= 1'b0;
    #1 chk(32'(step_out), 32'(exp));
  endtask : step

  task automatic pulse(input logic [7:0] dly, input logic [7:0] len);
    @(posedge clock);
    fire <= 1'b1;
    delay_cycles <= dly;
    pulse_cycles <= len;
    @(posedge clock);
    fire <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(posedge clock);
    wait_cyc(6);
  endtask : pulse

  ////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [6:0] addrs [8] = '{OCC_ADDR_GLOBAL_CONF, OCC_ADDR_REF_CONF, OCC_ADDR_FORMAT, OCC_ADDR_STATE,
      OCC_ADDR_IRQ_STATUS, OCC_ADDR_IRQ_MASK, OCC_ADDR_THRESH_VEL, 7'h7f};
    setup(4'h0, 2'b00, 32'h0, 32'h0);
    chk(32'(commutation_enable_oe_n), 32'h1);
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      chk(d, 32'h0);
    end
    wr(OCC_ADDR_FORMAT, 32'hffff_ffff);
    rd(OCC_ADDR_FORMAT, d);
    chk(d, 32'h0000_000f);
    wr(7'h7f, 32'h1234_5678);
    rd(7'h7f, d);
    chk(d, 32'h0);
  endtask : test_regs

  task automatic test_gating();
    setup(OCC_FMT_F1_A, OCC_MODE_ON, 32'h0, 32'h0000_0100);
    chk(32'(full_step_mode), 32'h1);
    step(1'b1);
    pulse(8'h00, 8'h03);
    rd(OCC_ADDR_STATE, d);
    chk(32'(d[3]), 32'h1);
    chk(32'(d[2]), 32'h0);
    step(1'b0);
    pulse(8'h00, 8'd18);
    rd(OCC_ADDR_STATE, d);
    chk(32'(d[3]), 32'h0);
    chk(32'(d[2]), 32'h0);
    step(1'b1);
  endtask : test_gating

  task automatic test_stall_irq();
    setup(OCC_FMT_F1_A, OCC_MODE_ON, 32'h0, 32'h0000_0100);
    wr(OCC_ADDR_IRQ_MASK, 32'h7);
    step(1'b1);
    wait_cyc(20);
    pulse(8'h00, 8'd10);
    rd(OCC_ADDR_STATE, d);
    chk(32'(d[2]), 32'h1);
    chk(32'(stall_report), 32'h1);
    chk(32'(irq), 32'h1);
    rd(OCC_ADDR_IRQ_STATUS, d);
    chk(32'(d[OCC_IRQ_STALL]), 32'h1);
    wr(OCC_ADDR_IRQ_MASK, 32'h0);
    wait_cyc(2);
    chk(32'(irq), 32'h0);
    wr(OCC_ADDR_IRQ_STATUS, 32'h7);
    wr(OCC_ADDR_IRQ_MASK, 32'h7);
    rd(OCC_ADDR_IRQ_STATUS, d);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
  endtask : test_stall_irq

  task automatic test_overload();
    logic got;
    got = 1'b0;
    setup(OCC_FMT_F1_B, OCC_MODE_ON, 32'd200, 32'h0000_0100);
    step(1'b1);
    wait_cyc(20);
    pulse(8'h00, 8'd25);
    rd(OCC_ADDR_STATE, d);
    chk(32'(d[3]), 32'h1);
    rd(OCC_ADDR_IRQ_STATUS, d);
    chk(32'(d[OCC_IRQ_OVERLOAD]), 32'h1);
    for (int i = 0; i < 400 && !got; i++) begin
      @(posedge clock);
      #1 got = (step_out === 1'b1);
    end
    chk(32'(got), 32'h1);
    rd(OCC_ADDR_IRQ_STATUS, d);
    chk(32'(d[OCC_IRQ_FORCED]), 32'h1);
  endtask : test_overload

  task automatic test_cover();
    logic got;
    got = 1'b0;
    setup(OCC_FMT_F1_B, OCC_MODE_ON, 32'h0, 32'h0000_0010);
    wr(OCC_ADDR_CHOP_LOW, 32'h1111_2222);
    wr(OCC_ADDR_CHOP_HIGH, 32'h3333_4444);
    wr(OCC_ADDR_SWITCH_VEL, 32'h0000_000f);
    wr(OCC_ADDR_REF_CONF, 32'h1);
    rd(OCC_ADDR_SWITCH_VEL, d);
    chk(d, 32'h0000_000f);
    wait_cyc(3);
    chk(32'(full_step_mode), 32'h0);
    chk(chopper_datagram, 32'h1111_2222);
    @(posedge clock);
    internal_velocity <= 32'hffff_ff00;
    for (int i = 0; i < 10 && !got; i++) begin
      @(posedge clock);
      #1 got = (cover_send === 1'b1);
    end
    chk(32'(got), 32'h1);
    wait_cyc(2);
    chk(chopper_datagram, 32'h3333_4444);
    chk(32'(full_step_mode), 32'h1);
  endtask : test_cover

  task automatic test_family_two();
    setup(OCC_FMT_F2_A, OCC_MODE_ON, 32'h0, 32'h0000_0010);
    wr(OCC_ADDR_CHOP_HIGH, 32'h5555_6666);
    wait_cyc(2);
    chk(chopper_datagram, 32'h5555_6666);
    chk(32'(commutation_enable_output), 32'h1);
    chk(32'(commutation_enable_oe_n), 32'h0);
    chk(32'(full_step_mode), 32'h1);
    step(1'b1);
    step(1'b1);
    wr(OCC_ADDR_FORMAT, 32'(OCC_FMT_F2_B));
    wait_cyc(3);
    chk(32'(commutation_enable_output), 32'h1);
    @(posedge clock);
    internal_velocity <= 32'h0000_000f;
    wait_cyc(3);
    chk(32'(commutation_enable_output), 32'h0);
    chk(chopper_datagram, OCC_RESET_WORD);
    @(posedge clock);
    internal_velocity <= 32'hffff_ff00;
    wait_cyc(3);
    chk(32'(commutation_enable_output), 32'h0);
  endtask : test_family_two

  task automatic test_mode_off();
    setup(OCC_FMT_F1_A, 2'b10, 32'h0, 32'h0000_0100);
    chk(32'(full_step_mode), 32'h0);
    step(1'b1);
    step(1'b1);
    @(posedge clock);
    driver_stall_status <= 1'b1;
    wait_cyc(3);
    chk(32'(stall_report), 32'h1);
    wr(OCC_ADDR_FORMAT, 32'(OCC_FMT_F2_A));
    wait_cyc(3);
    chk(32'(commutation_enable_output), 32'h0);
    chk(32'(commutation_enable_oe_n), 32'h1);
    @(posedge clock);
    driver_stall_status <= 1'b0;
  endtask : test_mode_off

  initial begin
    {rst, reg_write, reg_read, step_request, driver_stall_status, fire} = 6'b100000;
    reg_addr = 7'h00;
    reg_wdata = 32'h0;
    internal_velocity = 32'h0;
    delay_cycles = 8'h00;
    pulse_cycles = 8'h00;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    test_regs();
    test_gating();
    test_stall_irq();
    test_overload();
    test_cover();
    test_family_two();
    test_mode_off();
    stop_test();
  end
endmodule : overload_commutation_ctrl_bench
`default_nettype wire
